//--- hdl/gpio_port_with_irq.sv
/*
  One general-purpose I/O port: APB register slave, pin value access masked by
  address bits, per-pin direction, peripheral takeover, interrupt detection with
  raw and masked flags, one port interrupt and an optional converter trigger.
  Assumes pad inputs are asynchronous, peripheral signals share clock_in and the
  single reset input already combines power-on and external reset.
  Pins without a pad are cut off by PAD_PRESENT at every register but the takeover reset value, which takes DEBUG_PINS unmasked.

  // How it works
  // RQ1: Ordinary pins reset as software-controlled inputs.
  // RQ2: Debug pins reset owned by their peripheral.
  // RQ3: Any reset restores every pin's default.
  // RQ4: Address bits nine to two mask value access.
  // RQ5: Masked value write changes only selected bits.
  // RQ6: Masked value read returns zero elsewhere.
  // RQ7: Direction bit chooses input or driven output.
  // RQ8: One interrupt line for the whole port.
  // RQ9: Edge flags stay latched until software clears.
  // RQ10: Level sources hold level until recognised.
  // RQ11: Rising, falling, both, high or low detection.
  // RQ12: Enable bit forwards a pin's interrupt.
  // RQ13: Raw flags ignore the enable bits.
  // RQ14: Masked flags are raw and enabled.
  // RQ15: Enabled trigger pin event pulses converter trigger.
  // RQ16: Writing one clears a flag; zero does nothing.
  // RQ17: Detection setting writes may raise spurious flags.
  // RQ18: Software disables interrupt before changing detection.
  // RQ19: Takeover gives the peripheral the pad.
  // RQ20: No takeover means software drives pad.
  // RQ21: Every port is this same block.
  // RQ22: Fixed identification words are readable.
  // RQ23: Padless bits ignore writes, read zero.
  // RQ24: Interrupt is OR of raw AND enable.
  // RQ25: Pins synchronised, edges from consecutive samples.
*/
`timescale 1ns/1ps

module gpio_port_with_irq #(
  parameter int PIN_COUNT = gpio_port_pkg::PINS,
  parameter logic [7:0] PAD_PRESENT = 8'hff,
  parameter logic [7:0] DEBUG_PINS = 8'h00,
  parameter bit TRIGGER_USED = 1'b0,
  parameter int TRIGGER_PIN = 4,
  parameter logic [31:0] BLOCK_IDENT = gpio_port_pkg::BLOCK_IDENT_DEFAULT
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [gpio_port_pkg::DATA_W-1:0] pwdata_in,
  output logic [gpio_port_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Package pins
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe_n_out,
  // Peripheral alternate signals
  input wire logic [PIN_COUNT-1:0] alt_value_in,
  input wire logic [PIN_COUNT-1:0] alt_drive_in,
  output logic [PIN_COUNT-1:0] alt_pin_out,
  // Interrupt controller and converter
  output logic irq_out,
  output logic converter_trigger_out
);

  localparam logic [PIN_COUNT-1:0] PAD_MASK = PAD_PRESENT[PIN_COUNT-1:0];
  localparam logic [PIN_COUNT-1:0] TAKEOVER_DEFAULT =
    gpio_port_pkg::TAKEOVER_RESET[PIN_COUNT-1:0] | DEBUG_PINS[PIN_COUNT-1:0];
  localparam logic [PIN_COUNT-1:0] CONFIG_DEFAULT = gpio_port_pkg::CONFIG_RESET[PIN_COUNT-1:0];

  logic [PIN_COUNT-1:0] pin_value_reg;
  logic [PIN_COUNT-1:0] pin_direction_bits;
  logic [PIN_COUNT-1:0] irq_sense_select;
  logic [PIN_COUNT-1:0] irq_dual_edge_select;
  logic [PIN_COUNT-1:0] irq_polarity_select;
  logic [PIN_COUNT-1:0] irq_enable_bits;
  logic [PIN_COUNT-1:0] irq_raw_flags;
  logic [PIN_COUNT-1:0] irq_raw_next;
  logic [PIN_COUNT-1:0] irq_masked_flags;
  logic [PIN_COUNT-1:0] irq_clear_bits;
  logic [PIN_COUNT-1:0] peripheral_takeover_select;
  logic [PIN_COUNT-1:0] sync_first_reg;
  logic [PIN_COUNT-1:0] sync_second_reg;
  logic [PIN_COUNT-1:0] sample_prev_reg;
  logic [PIN_COUNT-1:0] pin_event;
  logic [PIN_COUNT-1:0] addr_mask;
  logic [PIN_COUNT-1:0] value_read;
  logic [PIN_COUNT-1:0] wdata_pins;
  logic [gpio_port_pkg::DATA_W-1:0] read_word;
  logic read_error;
  logic access_done;
  logic write_done;
  logic value_area;
  logic write_value;
  logic write_direction;
  logic write_sense;
  logic write_dual_edge;
  logic write_polarity;
  logic write_enable;
  logic write_clear;
  logic write_takeover;
  logic ident_area;
  logic word_aligned;
  logic [PIN_COUNT-1:0] driven_pins;
  logic [gpio_port_pkg::DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic trigger_reg;
  logic [PIN_COUNT-1:0] pad_out_reg;
  logic [PIN_COUNT-1:0] pad_oe_n_reg;
  logic [PIN_COUNT-1:0] alt_pin_reg;

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_out = irq_reg;
  assign converter_trigger_out = trigger_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe_n_out = pad_oe_n_reg;
  assign alt_pin_out = alt_pin_reg;

  // The answer is prepared in the setup cycle so that read data leaves a flop;
  // the cost is that every transfer has exactly one access cycle, never zero.
  assign access_done = psel_in & penable_in & pready_reg;
  assign write_done = access_done & pwrite_in;
  assign value_area = (paddr_in[11:10] == gpio_port_pkg::VALUE_AREA);
  assign addr_mask = paddr_in[gpio_port_pkg::MASK_LSB +: PIN_COUNT] & PAD_MASK; // [RQ4] [RQ23]
  assign wdata_pins = pwdata_in[PIN_COUNT-1:0] & PAD_MASK; // [RQ23]

  // One strobe per register, so each register block below only asks whether it
  // is its turn; all of them fire at the edge that ends the access cycle.
  assign write_value = write_done & value_area;
  assign write_direction = write_done & (paddr_in == gpio_port_pkg::DIRECTION_OFFSET);
  assign write_sense = write_done & (paddr_in == gpio_port_pkg::SENSE_OFFSET);
  assign write_dual_edge = write_done & (paddr_in == gpio_port_pkg::DUAL_EDGE_OFFSET);
  assign write_polarity = write_done & (paddr_in == gpio_port_pkg::POLARITY_OFFSET);
  assign write_enable = write_done & (paddr_in == gpio_port_pkg::ENABLE_OFFSET);
  assign write_clear = write_done & (paddr_in == gpio_port_pkg::CLEAR_OFFSET);
  assign write_takeover = write_done & (paddr_in == gpio_port_pkg::TAKEOVER_OFFSET);
  assign irq_clear_bits = write_clear ? wdata_pins : '0; // [RQ16]
  assign irq_masked_flags = irq_raw_flags & irq_enable_bits; // [RQ14] [RQ24]

  // The identification words are the only mapped area above the pin registers.
  assign ident_area = (paddr_in >= gpio_port_pkg::IDENT_FIRST_OFFSET) &&
    (paddr_in <= gpio_port_pkg::IDENT_LAST_OFFSET);
  assign word_aligned = (paddr_in[1:0] == 2'h0);

  // Software-owned outputs read back what is driven; every other pin reads the
  // synchronised pad, so a peripheral-owned pin still shows its real level.
  assign driven_pins = pin_direction_bits & ~peripheral_takeover_select; // [RQ7] [RQ20]
  assign value_read = ((driven_pins & pin_value_reg) | (~driven_pins & sync_second_reg)) &
    addr_mask; // [RQ6]

  always_comb begin
    read_word = gpio_port_pkg::READ_ZERO;
    read_error = 1'b0;
    if (value_area) begin
      read_word[PIN_COUNT-1:0] = value_read; // [RQ6]
    end else begin
      unique case (paddr_in)
        gpio_port_pkg::DIRECTION_OFFSET: read_word[PIN_COUNT-1:0] = pin_direction_bits;
        gpio_port_pkg::SENSE_OFFSET: read_word[PIN_COUNT-1:0] = irq_sense_select;
        gpio_port_pkg::DUAL_EDGE_OFFSET: read_word[PIN_COUNT-1:0] = irq_dual_edge_select;
        gpio_port_pkg::POLARITY_OFFSET: read_word[PIN_COUNT-1:0] = irq_polarity_select;
        gpio_port_pkg::ENABLE_OFFSET: read_word[PIN_COUNT-1:0] = irq_enable_bits;
        gpio_port_pkg::RAW_OFFSET: read_word[PIN_COUNT-1:0] = irq_raw_flags; // [RQ13]
        gpio_port_pkg::MASKED_OFFSET: read_word[PIN_COUNT-1:0] = irq_masked_flags; // [RQ14]
        gpio_port_pkg::CLEAR_OFFSET: read_word = gpio_port_pkg::READ_ZERO;
        gpio_port_pkg::TAKEOVER_OFFSET: read_word[PIN_COUNT-1:0] = peripheral_takeover_select;
        gpio_port_pkg::BLOCK_IDENT_OFFSET: read_word = BLOCK_IDENT; // [RQ22]
        default: begin
          // Other identification words read as zero; anything else is an error.
          if (!ident_area || !word_aligned) begin
            read_error = 1'b1;
          end
        end
      endcase
    end
  end

  // Ready comes exactly one cycle after each setup cycle and is never held.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel_in & ~penable_in;
    end
  end

  // Read data is captured in the setup cycle and held until the next one, so
  // the access cycle never waits on the register decode.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_reg <= gpio_port_pkg::READ_ZERO;
    end else if (psel_in && !penable_in) begin
      prdata_reg <= pwrite_in ? gpio_port_pkg::READ_ZERO : read_word;
    end
  end

  // The error flag stands only in the access cycle, beside ready.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel_in & ~penable_in & read_error;
    end
  end

  // Pin value register: only bits selected by the address mask change.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_value_reg <= CONFIG_DEFAULT;
    end else if (write_value) begin
      pin_value_reg <= (pin_value_reg & ~addr_mask) | (wdata_pins & addr_mask); // [RQ5]
    end
  end

  // One asynchronous reset serves both power-on and external reset.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_direction_bits <= CONFIG_DEFAULT; // [RQ1] [RQ3]
    end else if (write_direction) begin
      pin_direction_bits <= wdata_pins; // [RQ7]
    end
  end

  // Debug pins come out of every reset owned by their peripheral, so a debugger
  // can reach the part before any software has run.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      peripheral_takeover_select <= TAKEOVER_DEFAULT; // [RQ1] [RQ2] [RQ3]
    end else if (write_takeover) begin
      peripheral_takeover_select <= wdata_pins; // [RQ19] [RQ20]
    end
  end

  // Each detection setting takes effect at once; a write may therefore raise a flag.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_sense_select <= CONFIG_DEFAULT;
    end else if (write_sense) begin
      irq_sense_select <= wdata_pins; // [RQ11] [RQ17]
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_dual_edge_select <= CONFIG_DEFAULT;
    end else if (write_dual_edge) begin
      irq_dual_edge_select <= wdata_pins; // [RQ11]
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_polarity_select <= CONFIG_DEFAULT;
    end else if (write_polarity) begin
      irq_polarity_select <= wdata_pins; // [RQ11]
    end
  end

  // Clearing an enable bit hides a flag from the line but keeps the raw flag.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_enable_bits <= CONFIG_DEFAULT;
    end else if (write_enable) begin
      irq_enable_bits <= wdata_pins; // [RQ12]
    end
  end

  // The first stage feeds only the second; detection looks at later stages.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_first_reg <= '0;
      sync_second_reg <= '0;
    end else begin
      sync_first_reg <= pad_in; // [RQ25]
      sync_second_reg <= sync_first_reg; // [RQ25]
    end
  end

  // A third stage keeps the previous sample, so an edge is one sample against the next.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_prev_reg <= '0;
    end else begin
      sample_prev_reg <= sync_second_reg; // [RQ25]
    end
  end

  // Per-pin detection, identical for every pin of every port instance.
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_detect // [RQ21]
    logic rise;
    logic fall;
    logic edge_hit;
    logic level_hit;
    assign rise = sync_second_reg[i] & ~sample_prev_reg[i]; // [RQ25]
    assign fall = ~sync_second_reg[i] & sample_prev_reg[i]; // [RQ25]
    assign edge_hit = irq_dual_edge_select[i] ? (rise | fall) :
      (irq_polarity_select[i] ? rise : fall); // [RQ11]
    assign level_hit = irq_polarity_select[i] ? sync_second_reg[i] : ~sync_second_reg[i]; // [RQ11]
    // A level flag follows the pin; an edge flag holds until cleared, and a new
    // edge in the clearing cycle wins. Changing the detection settings takes
    // effect at once, so a flag may appear without a real pin event.
    assign irq_raw_next[i] = !PAD_MASK[i] ? 1'b0 :
      irq_sense_select[i] ? level_hit :
      (edge_hit | (irq_raw_flags[i] & ~irq_clear_bits[i])); // [RQ9] [RQ16] [RQ17]
    assign pin_event[i] = irq_raw_next[i] & (~irq_raw_flags[i] | edge_hit);
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_raw_flags <= '0;
    end else begin
      irq_raw_flags <= irq_raw_next; // [RQ9] [RQ13]
    end
  end

  // The line follows the next raw flags, so it rises in the same cycle as the flag.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_raw_next & irq_enable_bits); // [RQ8] [RQ12] [RQ24]
    end
  end

  // Only a new event pulses the trigger, so a held level gives a single pulse.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trigger_reg <= 1'b0;
    end else begin
      trigger_reg <= TRIGGER_USED & irq_enable_bits[TRIGGER_PIN] &
        pin_event[TRIGGER_PIN]; // [RQ15]
    end
  end

  // Pad control; the enable is low while the pad is driven.
  // Pins without a pad are never driven, whoever owns them.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pad_out_reg <= '0;
    end else begin
      pad_out_reg <= PAD_MASK & ((peripheral_takeover_select & alt_value_in) |
        (~peripheral_takeover_select & pin_value_reg)); // [RQ19] [RQ20]
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pad_oe_n_reg <= '1; // [RQ1] [RQ3]
    end else begin
      pad_oe_n_reg <= ~(PAD_MASK & ((peripheral_takeover_select & alt_drive_in) |
        driven_pins)); // [RQ7] [RQ19] [RQ20]
    end
  end

  // Peripheral-owned pins pass the synchronised pad on; the others show zero.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alt_pin_reg <= '0;
    end else begin
      alt_pin_reg <= peripheral_takeover_select & sync_second_reg; // [RQ19]
    end
  end

endmodule

//--- hdl/gpio_port_pkg.sv
/*
  Constants shared by the general-purpose I/O port: register byte offsets on the
  APB bus, reset values of the configuration registers and sizes of the port.
  Assumes a 12-bit byte address within one port's 4 KB window.
*/
package gpio_port_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PINS = 8;

  // The pin value register spans offsets 0x000 to 0x3fc; these bits pick that area.
  localparam logic [1:0] VALUE_AREA = 2'h0;
  localparam int MASK_LSB = 2;

  localparam logic [11:0] DIRECTION_OFFSET = 12'h400;
  localparam logic [11:0] SENSE_OFFSET = 12'h404;
  localparam logic [11:0] DUAL_EDGE_OFFSET = 12'h408;
  localparam logic [11:0] POLARITY_OFFSET = 12'h40c;
  localparam logic [11:0] ENABLE_OFFSET = 12'h410;
  localparam logic [11:0] RAW_OFFSET = 12'h414;
  localparam logic [11:0] MASKED_OFFSET = 12'h418;
  localparam logic [11:0] CLEAR_OFFSET = 12'h41c;
  localparam logic [11:0] TAKEOVER_OFFSET = 12'h420;
  localparam logic [11:0] IDENT_FIRST_OFFSET = 12'hfd0;
  localparam logic [11:0] IDENT_LAST_OFFSET = 12'hffc;
  localparam logic [11:0] BLOCK_IDENT_OFFSET = 12'hfe0;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] TAKEOVER_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Value is arbitrary; it only lets software recognise the block.
  localparam logic [31:0] BLOCK_IDENT_DEFAULT = 32'h0000005a;

endpackage

//--- verif/pad_model.sv
/*
  Outside world of one port: each pin shows the port's drive when enabled,
  otherwise a level from an outside source set by the bench.
*/
`timescale 1ns/1ps
module pad_model (
  // Port and source side
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] level_in,
  // Pins
  output logic [7:0] pin_out
);
  // The source holds each level steady until the port has seen it.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_out[i] = oe_n_in[i] ? level_in[i] : drive_in[i];
    end
  end
endmodule

//--- verif/gpio_port_chk.sv
/*
  Checker on the port's own pins.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module gpio_port_chk #(
  parameter int PIN_COUNT = 8,
  parameter logic [31:0] BLOCK_IDENT = 32'h00000000
) (
  // Clock, reset and APB
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins, peripheral and interrupt
  input wire logic [PIN_COUNT-1:0] pad_in,
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe_n_out,
  input wire logic [PIN_COUNT-1:0] alt_pin_out,
  input wire logic irq_out,
  input wire logic converter_trigger_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  logic [7:0] mask_reg;
  wire setup = psel_in && !penable_in;
  wire value = setup && paddr_in[11:10] == 2'h0;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_reg <= 8'h00;
    end else begin
      mask_reg <= paddr_in[9:2];
    end
  end
  a_ready_after_setup: assert property (setup |=> pready_out)
    else $error("no ready in access cycle");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_value_no_error: assert property (value |=> !pslverr_out)
    else $error("value access refused");
  a_read_masked: assert property (value && !pwrite_in |=>
    (prdata_out & ~{24'h0, mask_reg}) == 32'h0)
    else $error("unmasked bit read back");
  a_ident_value: assert property (setup && paddr_in == 12'hfe0 ##1 !pwrite_in |->
    prdata_out == BLOCK_IDENT)
    else $error("wrong identification");
  a_reset_inputs: assert property ($rose(resetn_in) |-> pad_oe_n_out == '1)
    else $error("pin driven after reset");
  a_reset_quiet: assert property ($rose(resetn_in) |-> !irq_out && alt_pin_out == '0)
    else $error("outputs active after reset");
  a_trigger_irq: assert property (converter_trigger_out |-> irq_out)
    else $error("trigger without interrupt");
  c_value_write: cover property (value && pwrite_in);
  c_irq_rise: cover property ($rose(irq_out));
  c_trigger: cover property (converter_trigger_out);
endmodule

bind gpio_port_with_irq gpio_port_chk #(.PIN_COUNT(PIN_COUNT), .BLOCK_IDENT(BLOCK_IDENT))
  gpio_port_chk_inst (.clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out), .alt_pin_out(alt_pin_out),
  .irq_out(irq_out), .converter_trigger_out(converter_trigger_out));

//--- verif/testbench.sv
/*
  Self-checking bench for one port: APB master tasks and one task per scenario.
  Assumes the checker is bound to the port and the pad model closes the pins.
*/
`timescale 1ns/1ps
module testbench;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [7:0] alt_value_in = 8'h00;
  logic [7:0] alt_drive_in = 8'h00;
  logic [7:0] level = 8'h00;
  logic [31:0] prdata_out, q;
  logic pready_out, pslverr_out, irq_out, converter_trigger_out, e;
  logic trig_seen = 1'b0;
  logic [7:0] pad_in, pad_out, pad_oe_n_out, alt_pin_out;
  int fails = 0;
  int checks_done = 0;
  logic [2:0] modes [5] = '{3'b001, 3'b000, 3'b010, 3'b101, 3'b100};
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) if (converter_trigger_out === 1'b1) trig_seen <= 1'b1;
  gpio_port_with_irq #(.DEBUG_PINS(8'h80), .TRIGGER_USED(1'b1)) gpio_port_with_irq_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n_out(pad_oe_n_out), .alt_value_in(alt_value_in), .alt_drive_in(alt_drive_in),
    .alt_pin_out(alt_pin_out), .irq_out(irq_out), .converter_trigger_out(converter_trigger_out));
  pad_model pad_model_inst (.drive_in(pad_out), .oe_n_in(pad_oe_n_out), .level_in(level),
    .pin_out(pad_in));
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1) begin
      @(posedge clock_in);
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    compare(q, exp);
  endtask
  task automatic t_reset;
    rchk(12'h400, 32'h0);
    rchk(12'h420, 32'h80);
    rchk(12'hfe0, gpio_port_pkg::BLOCK_IDENT_DEFAULT);
    compare({24'h0, pad_oe_n_out}, 32'hff);
    apb(1'b0, 12'h500, 32'h0);
    compare({31'h0, e}, 32'h1);
  endtask
  task automatic t_value;
    apb(1'b1, 12'h400, 32'h7f);
    apb(1'b1, 12'h3fc, 32'hff);
    apb(1'b1, 12'h098, 32'heb);
    tick(1);
    compare({25'h0, pad_out[6:0]}, 32'h7b);
    compare({25'h0, pad_oe_n_out[6:0]}, 32'h0);
    rchk(12'h0c4, 32'h31);
    rchk(12'h3fc, 32'h7b);
  endtask
  task automatic t_takeover;
    alt_drive_in <= 8'h84;
    alt_value_in <= 8'h84;
    tick(6);
    compare({24'h0, pad_out}, 32'hfb);
    compare({24'h0, pad_oe_n_out}, 32'h0);
    compare({24'h0, alt_pin_out}, 32'h80);
    alt_drive_in <= 8'h00;
    apb(1'b1, 12'h400, 32'h0);
  endtask
  task automatic t_modes;
    logic [2:0] m;
    trig_seen <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      m = modes[i];
      level[4] <= ~m[0];
      apb(1'b1, 12'h410, 32'h0);
      apb(1'b1, 12'h404, {27'h0, m[2], 4'h0});
      apb(1'b1, 12'h408, {27'h0, m[1], 4'h0});
      apb(1'b1, 12'h40c, {27'h0, m[0], 4'h0});
      tick(4);
      apb(1'b1, 12'h41c, 32'hff);
      apb(1'b1, 12'h410, 32'h10);
      tick(1);
      compare({31'h0, irq_out}, 32'h0);
      level[4] <= m[0];
      tick(6);
      compare({31'h0, irq_out}, 32'h1);
      level[4] <= ~m[0];
      tick(6);
      compare({31'h0, irq_out}, {31'h0, ~m[2]});
    end
    compare({31'h0, trig_seen}, 32'h1);
  endtask
  task automatic t_mask;
    apb(1'b1, 12'h410, 32'h0);
    apb(1'b1, 12'h404, 32'h0);
    level[4] <= 1'b0;
    trig_seen <= 1'b0;
    tick(6);
    compare({31'h0, trig_seen}, 32'h0);
    rchk(12'h414, 32'h10);
    rchk(12'h418, 32'h0);
    compare({31'h0, irq_out}, 32'h0);
    apb(1'b1, 12'h410, 32'h10);
    tick(1);
    rchk(12'h418, 32'h10);
    compare({31'h0, irq_out}, 32'h1);
    apb(1'b1, 12'h41c, 32'hef);
    tick(1);
    compare({31'h0, irq_out}, 32'h1);
    apb(1'b1, 12'h41c, 32'h10);
    tick(1);
    compare({31'h0, irq_out}, 32'h0);
    rchk(12'h414, 32'h0);
  endtask
  task automatic t_rereset;
    apb(1'b1, 12'h400, 32'hff);
    apb(1'b1, 12'h420, 32'h01);
    resetn_in <= 1'b0;
    tick(2);
    resetn_in <= 1'b1;
    tick(1);
    compare({24'h0, pad_oe_n_out}, 32'hff);
    rchk(12'h420, 32'h80);
    rchk(12'h410, 32'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    resetn_in <= 1'b1;
    tick(1);
    t_reset();
    t_value();
    t_takeover();
    t_modes();
    t_mask();
    t_rereset();
    test_done();
  end
  // The scenarios need well under a thousand cycles; this allows five thousand.
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule
